// File: hw/tio_port_block.sv
// Operation
// - all pins of a port share one direction, input or output
// - ports of widths 1, 4, 8, 16 and 32 bits map onto pins
// - port drives pins or samples them, optionally waiting for a condition
// - open-drain: zero drives low, one leaves pin undriven
// - output data passes through a transfer register and a port value stage; input data is captured straight into the transfer register
// - 16-bit counter readable anytime; can gate transfers to a set count
// - each transfer captures the counter as a timestamp
// - an enabled link stops every port driving its shared pins; inputs still sample them
// - narrower enabled port wins shared pins; other pins stay with wider
// - a port always transfers at its full declared width
// - six clock blocks; block 0 is the tile reference clock
// - clock block may use the 1-bit port pin, optionally divided
// - ports accept an incoming ready strobe and emit an output strobe
// - after reset every port uses clock block 0
// - every processor access to a port completes in one cycle
// - pin conditions raise events straight to the scheduler
// - pull-downs enabled on all pins while in reset
//
// Chosen here: the strobed register port and the register offsets.
`timescale 1ns/1ps
`include "tio_defines.svh"

module tio_port_block #(
	parameter int PIN_W = `TIO_W_P4,
	parameter logic [PIN_W-1:0] LINK_PINS = '0
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic sys_rst_i,
	// register port
	input wire logic [7:0] addr_i,
	input wire logic [`TIO_DW-1:0] wdata_i,
	input wire logic we_i,
	input wire logic re_i,
	output logic [`TIO_DW-1:0] rdata_o,
	// pins
	input wire logic [PIN_W-1:0] pin_i,
	output logic [PIN_W-1:0] pin_o,
	output logic [PIN_W-1:0] pin_oe_o,
	output logic [PIN_W-1:0] pin_pd_o,
	// strobes
	input wire logic strobe_in_ready_i,
	output logic strobe_out_valid_o,
	// link mux
	input wire logic link_en_i,
	// events and interrupt
	output logic [`TIO_NPORT-1:0] events_o,
	output logic irq_o
);
	localparam int NP = `TIO_NPORT;
	localparam int NCB = `TIO_NCB;
	localparam int PORT_W [NP] = '{`TIO_W_P0, `TIO_W_P1, `TIO_W_P2,
		`TIO_W_P3, `TIO_W_P4};

	tio_pkg::tio_ctrl_s ctrl_ff [NP];
	logic [`TIO_DW-1:0] dout_ff [NP];
	logic [`TIO_DW-1:0] pval_ff [NP];
	logic [`TIO_DW-1:0] din_ff [NP];
	logic [`TIO_DW-1:0] cval_ff [NP];
	logic [`TIO_CW-1:0] time_ff [NP];
	logic [`TIO_CW-1:0] cnt_ff [NP];
	logic [`TIO_CW-1:0] ts_ff [NP];
	logic [NP-1:0] pend_ff;
	logic [NP-1:0] dvalid_ff;
	logic [NP-1:0] xfer_in;
	logic [NP-1:0] xfer_out;
	logic [NP-1:0] status_ff;
	logic [NP-1:0] mask_ff;
	logic [NP-1:0] events_ff;
	logic [NP-1:0] port_wr;
	logic [NP-1:0] port_rd;
	logic [7:0] cb_tick;
	logic [NCB-1:0] cb_en_ff;
	logic [`TIO_DIV_W-1:0] cb_div_ff [NCB];
	logic [`TIO_DIV_W-1:0] cb_cnt_ff [NCB];
	logic [PIN_W-1:0] pin_m_ff;
	logic [PIN_W-1:0] pin_s_ff;
	logic [PIN_W-1:0] pin_q_ff;
	logic [PIN_W-1:0] pin_o_ff;
	logic [PIN_W-1:0] pin_oe_ff;
	logic [PIN_W-1:0] pd_ff;
	logic rdy_m_ff;
	logic rdy_s_ff;
	logic stb_ff;
	logic [`TIO_DW-1:0] rdata_ff;
	logic [`TIO_DW-1:0] nxt_rdata;
	logic src_edge;
	logic global_sel;
	logic [2:0] pidx;
	logic [2:0] rsel;

	assign global_sel = addr_i[`TIO_GLOBAL_BIT];
	assign pidx = addr_i[`TIO_PIDX_HI:`TIO_PIDX_LO];
	assign rsel = addr_i[`TIO_REG_HI:0];

	// pins and strobe come from outside: two stages before any use
	always_ff @(posedge clk_i) begin
		pin_m_ff <= pin_i;
		pin_s_ff <= pin_m_ff;
		pin_q_ff <= pin_s_ff;
		rdy_m_ff <= strobe_in_ready_i;
		rdy_s_ff <= rdy_m_ff;
	end

	// pull-downs held on through reset, released at the first clean edge
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			pd_ff <= '1;
		end else begin
			pd_ff <= '0;
		end
	end

	// clock blocks; block 0 ticks on every rising edge of the reference clock
	assign src_edge = pin_s_ff[0] & ~pin_q_ff[0];
	assign cb_tick[0] = 1'b1;
	assign cb_tick[7:NCB] = '0;
	assign cb_en_ff[0] = 1'b0;
	assign cb_div_ff[0] = '0;
	assign cb_cnt_ff[0] = '0;

	genvar g;
	generate
		for (g = 1; g < NCB; g++) begin : g_cb
			// the 1-bit port pin is the source; div n gives one tick per n+1 edges
			assign cb_tick[g] = cb_en_ff[g] && src_edge &&
				cb_cnt_ff[g] == cb_div_ff[g];
			always_ff @(posedge clk_i) begin
				if (sys_rst_i) begin
					cb_en_ff[g] <= 1'b0;
					cb_div_ff[g] <= '0;
				end else if (we_i && addr_i == `TIO_ADDR_CB0 + 8'(g)) begin
					cb_en_ff[g] <= wdata_i[`TIO_CB_EN_BIT];
					cb_div_ff[g] <= wdata_i[`TIO_CB_DIV_HI:`TIO_CB_DIV_LO];
				end
			end
			always_ff @(posedge clk_i) begin
				if (sys_rst_i || !cb_en_ff[g] || cb_tick[g]) begin
					cb_cnt_ff[g] <= '0;
				end else if (src_edge) begin
					cb_cnt_ff[g] <= cb_cnt_ff[g] + 1'b1;
				end
			end
		end

		for (g = 0; g < NP; g++) begin : g_port
			localparam logic [`TIO_DW-1:0] WMASK = (PORT_W[g] >= `TIO_DW) ?
				'1 : `TIO_DW'((64'h1 << PORT_W[g]) - 64'h1);
			logic tick;
			logic cond_ok;
			logic time_ok;
			logic [`TIO_DW-1:0] sample;

			assign tick = cb_tick[ctrl_ff[g].clk_sel];
			// full declared width even if some pins belong elsewhere
			assign sample = `TIO_DW'(pin_s_ff) & WMASK;
			always_comb begin
				case (ctrl_ff[g].cond)
					tio_pkg::TIO_COND_NONE: cond_ok = 1'b1;
					tio_pkg::TIO_COND_EQ: cond_ok = sample == cval_ff[g];
					tio_pkg::TIO_COND_NEQ: cond_ok = sample != cval_ff[g];
					default: cond_ok = 1'b1;
				endcase
			end
			assign time_ok = !ctrl_ff[g].timed || cnt_ff[g] == time_ff[g];
			// a full input buffer stalls sampling until software reads it
			assign xfer_in[g] = ctrl_ff[g].en && !ctrl_ff[g].dir_out && tick &&
				!dvalid_ff[g] && cond_ok && time_ok &&
				(!ctrl_ff[g].strobe_en || rdy_s_ff);
			assign xfer_out[g] = ctrl_ff[g].en && ctrl_ff[g].dir_out && tick &&
				pend_ff[g] && time_ok;
			assign port_wr[g] = we_i && !global_sel && pidx == 3'(g);
			assign port_rd[g] = re_i && !global_sel && pidx == 3'(g);

			always_ff @(posedge clk_i) begin
				if (sys_rst_i) begin
					ctrl_ff[g] <= '0;
					time_ff[g] <= '0;
					cval_ff[g] <= '0;
				end else if (port_wr[g]) begin
					if (rsel == `TIO_REG_CTRL) begin
						ctrl_ff[g] <= tio_pkg::tio_ctrl_s'(wdata_i[`TIO_CTRL_W-1:0]);
					end
					if (rsel == `TIO_REG_TIME) begin
						time_ff[g] <= wdata_i[`TIO_CW-1:0];
					end
					if (rsel == `TIO_REG_COND) begin
						cval_ff[g] <= wdata_i & WMASK;
					end
				end
			end

			// output path: transfer register then port value on the pins
			always_ff @(posedge clk_i) begin
				if (sys_rst_i) begin
					dout_ff[g] <= '0;
					pval_ff[g] <= '0;
					pend_ff[g] <= 1'b0;
				end else begin
					if (xfer_out[g]) begin
						pval_ff[g] <= dout_ff[g];
					end
					if (port_wr[g] && rsel == `TIO_REG_DATA) begin
						dout_ff[g] <= wdata_i & WMASK;
						pend_ff[g] <= 1'b1;
					end else if (xfer_out[g]) begin
						pend_ff[g] <= 1'b0;
					end
				end
			end

			// input path: a capture in the read cycle keeps the valid flag
			always_ff @(posedge clk_i) begin
				if (sys_rst_i) begin
					din_ff[g] <= '0;
					dvalid_ff[g] <= 1'b0;
				end else if (xfer_in[g]) begin
					din_ff[g] <= sample;
					dvalid_ff[g] <= 1'b1;
				end else if (port_rd[g] && rsel == `TIO_REG_DATA) begin
					dvalid_ff[g] <= 1'b0;
				end
			end

			always_ff @(posedge clk_i) begin
				if (sys_rst_i) begin
					cnt_ff[g] <= '0;
				end else if (tick) begin
					cnt_ff[g] <= cnt_ff[g] + 1'b1;
				end
			end

			always_ff @(posedge clk_i) begin
				if (sys_rst_i) begin
					ts_ff[g] <= '0;
				end else if (xfer_in[g] || xfer_out[g]) begin
					ts_ff[g] <= cnt_ff[g];
				end
			end
		end

		// pin ownership: link first, then the narrowest enabled port
		for (g = 0; g < PIN_W; g++) begin : g_pin
			logic found;
			logic drv;
			logic val;
			always_comb begin
				found = 1'b0;
				drv = 1'b0;
				val = 1'b0;
				for (int k = 0; k < NP; k++) begin
					if (!found && ctrl_ff[k].en && g < PORT_W[k]) begin
						found = 1'b1;
						// one direction bit per port covers all its pins
						drv = ctrl_ff[k].dir_out;
						val = pval_ff[k][g];
						if (ctrl_ff[k].od) begin
							drv = ctrl_ff[k].dir_out && !pval_ff[k][g];
							val = 1'b0;
						end
					end
				end
				if (link_en_i && LINK_PINS[g]) begin
					drv = 1'b0;
					val = 1'b0;
				end
			end
			always_ff @(posedge clk_i) begin
				if (sys_rst_i) begin
					pin_o_ff[g] <= 1'b0;
					pin_oe_ff[g] <= 1'b0;
				end else begin
					pin_o_ff[g] <= val;
					pin_oe_ff[g] <= drv;
				end
			end
		end
	endgenerate

	// strobe accompanies each new output word for one cycle
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			stb_ff <= 1'b0;
		end else begin
			stb_ff <= 1'b0;
			for (int k = 0; k < NP; k++) begin
				if (xfer_out[k] && ctrl_ff[k].strobe_en) begin
					stb_ff <= 1'b1;
				end
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			events_ff <= '0;
		end else begin
			events_ff <= xfer_in | xfer_out;
		end
	end

	// sticky status, write one to clear; a new event wins the race
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			status_ff <= '0;
		end else if (we_i && addr_i == `TIO_ADDR_STATUS) begin
			status_ff <= (status_ff & ~wdata_i[NP-1:0]) | xfer_in | xfer_out;
		end else begin
			status_ff <= status_ff | xfer_in | xfer_out;
		end
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			mask_ff <= '0;
		end else if (we_i && addr_i == `TIO_ADDR_MASK) begin
			mask_ff <= wdata_i[NP-1:0];
		end
	end

	// read mux; unmapped addresses answer zero, never a stall
	always_comb begin
		nxt_rdata = '0;
		if (!global_sel && pidx < 3'(NP)) begin
			case (rsel)
				`TIO_REG_CTRL: nxt_rdata = `TIO_DW'(ctrl_ff[pidx]);
				`TIO_REG_DATA: nxt_rdata = din_ff[pidx];
				`TIO_REG_TIME: nxt_rdata = `TIO_DW'(time_ff[pidx]);
				`TIO_REG_COND: nxt_rdata = cval_ff[pidx];
				`TIO_REG_COUNT: nxt_rdata = `TIO_DW'(cnt_ff[pidx]);
				`TIO_REG_TSTAMP: nxt_rdata = `TIO_DW'(ts_ff[pidx]);
				default: nxt_rdata = '0;
			endcase
		end else if (addr_i == `TIO_ADDR_STATUS) begin
			nxt_rdata = `TIO_DW'(status_ff);
		end else if (addr_i == `TIO_ADDR_MASK) begin
			nxt_rdata = `TIO_DW'(mask_ff);
		end else if (addr_i[7:3] == `TIO_ADDR_CB0 >> 3 &&
			addr_i[`TIO_CB_IDX_HI:0] < 3'(NCB)) begin
			nxt_rdata[`TIO_CB_EN_BIT] = cb_en_ff[addr_i[`TIO_CB_IDX_HI:0]];
			nxt_rdata[`TIO_CB_DIV_HI:`TIO_CB_DIV_LO] =
				cb_div_ff[addr_i[`TIO_CB_IDX_HI:0]];
		end
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			rdata_ff <= '0;
		end else if (re_i) begin
			rdata_ff <= nxt_rdata;
		end else begin
			rdata_ff <= '0;
		end
	end

	assign rdata_o = rdata_ff;
	assign pin_o = pin_o_ff;
	assign pin_oe_o = pin_oe_ff;
	assign pin_pd_o = pd_ff;
	assign strobe_out_valid_o = stb_ff;
	assign events_o = events_ff;
	assign irq_o = |(status_ff & mask_ff);

	default clocking cb_a @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);

	a_reset_pulldown: assert property ($fell(sys_rst_i) |-> &pin_pd_o)
		else $error("pull-downs not on through reset");
	a_reset_clk0: assert property ($fell(sys_rst_i) |->
		ctrl_ff[NP-1].clk_sel == `TIO_CB_REF)
		else $error("port not on clock block 0 after reset");
	a_link_release: assert property (link_en_i |=>
		(pin_oe_o & LINK_PINS) == '0)
		else $error("port still drives link pins");
	a_od_no_high: assert property ((ctrl_ff[1].en && ctrl_ff[1].od &&
		!ctrl_ff[0].en) |=> !(|(pin_oe_o[3:0] & pin_o[3:0])))
		else $error("open-drain pin driven high");
	a_narrow_wins: assert property ((ctrl_ff[1].en &&
		ctrl_ff[1].dir_out && ctrl_ff[1].od && ctrl_ff[2].en &&
		!ctrl_ff[0].en && !link_en_i) |=>
		pin_oe_o[0] == !$past(pval_ff[1][0]))
		else $error("wider port took a shared pin");
	a_cnt_wrap: assert property ((g_port[0].tick &&
		cnt_ff[0] == 16'hffff) |=> cnt_ff[0] == 16'h0000)
		else $error("counter did not wrap");
	a_ts_capture: assert property ((xfer_in[1] || xfer_out[1]) |=>
		ts_ff[1] == $past(cnt_ff[1]))
		else $error("timestamp not captured");
	a_timed_gate: assert property ((xfer_out[2] &&
		ctrl_ff[2].timed) |=> ts_ff[2] == $past(time_ff[2]))
		else $error("timed transfer off its count");
	a_read_count: assert property ((re_i && addr_i == 8'h14) |=>
		rdata_o == `TIO_DW'($past(cnt_ff[2])))
		else $error("count read not answered next cycle");
	a_strobe_out: assert property ((xfer_out[2] &&
		ctrl_ff[2].strobe_en) |=> strobe_out_valid_o ##1
		(!strobe_out_valid_o || $past(xfer_out[2])))
		else $error("output strobe missing");
	a_event_pulse: assert property (xfer_in[0] |=>
		events_o[0] && status_ff[0])
		else $error("event not raised");

	c_timed_out: cover property (xfer_out[2] && ctrl_ff[2].timed);
	c_cond_in: cover property (xfer_in[0] &&
		ctrl_ff[0].cond == tio_pkg::TIO_COND_EQ);
	c_ext_clock: cover property (cb_tick[1] && xfer_in[3]);
	c_irq: cover property (irq_o);
endmodule // tio_port_block

// File: hw/tio_defines.svh
`ifndef TIO_DEFINES_SVH
`define TIO_DEFINES_SVH

// port widths, narrowest first
`define TIO_W_P0 1
`define TIO_W_P1 4
`define TIO_W_P2 8
`define TIO_W_P3 16
`define TIO_W_P4 32
`define TIO_NPORT 5
`define TIO_NCB 6
`define TIO_DW 32
`define TIO_CW 16

// register bus decode
`define TIO_GLOBAL_BIT 7
`define TIO_PIDX_HI 5
`define TIO_PIDX_LO 3
`define TIO_REG_HI 2
`define TIO_REG_CTRL 3'h0
`define TIO_REG_DATA 3'h1
`define TIO_REG_TIME 3'h2
`define TIO_REG_COND 3'h3
`define TIO_REG_COUNT 3'h4
`define TIO_REG_TSTAMP 3'h5
`define TIO_ADDR_STATUS 8'h80
`define TIO_ADDR_MASK 8'h81
`define TIO_ADDR_CB0 8'h88
`define TIO_CB_IDX_HI 2

// clock block register fields
`define TIO_CB_EN_BIT 0
`define TIO_CB_DIV_HI 15
`define TIO_CB_DIV_LO 8
`define TIO_DIV_W 8

// reference clock block
`define TIO_CB_REF 3'h0
`define TIO_CTRL_W 10

`endif

// File: hw/tio_pkg.sv
package tio_pkg;
	typedef enum logic [1:0] {
		TIO_COND_NONE = 2'h0,
		TIO_COND_EQ = 2'h1,
		TIO_COND_NEQ = 2'h2
	} tio_cond_e;

	typedef struct packed {
		logic [2:0] clk_sel;
		logic strobe_en;
		logic timed;
		tio_cond_e cond;
		logic od;
		logic dir_out;
		logic en;
	} tio_ctrl_s;
endpackage

// File: tb/tio_pin_model.sv
`timescale 1ns/1ps

module tio_pin_model (
	// clock
	input wire logic clk_i,
	// device pin side
	input wire logic [31:0] drv_i,
	input wire logic [31:0] oe_i,
	input wire logic [31:0] pd_i,
	// bench commands
	input wire logic [31:0] ext_oe_i,
	input wire logic [31:0] ext_val_i,
	input wire logic rdy_i,
	// towards the device
	output logic [31:0] pin_o,
	output logic ready_o
);
	logic [31:0] float_ff = 32'h5a5a_0f0f;

	// no keeper on the pins: an undriven pin must not look like a stable level
	always_ff @(posedge clk_i) begin
		float_ff <= ~float_ff;
	end

	always_comb begin
		for (int i = 0; i < 32; i++) begin
			if (oe_i[i])
				pin_o[i] = drv_i[i];
			else if (ext_oe_i[i])
				pin_o[i] = ext_val_i[i];
			else if (pd_i[i])
				pin_o[i] = 1'b0;
			else
				pin_o[i] = float_ff[i];
		end
	end

	// the strobe only accompanies data really placed on the pins
	assign ready_o = rdy_i & (|ext_oe_i);
endmodule // tio_pin_model

// File: tb/tio_port_block_tb.sv
`timescale 1ns/1ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin errors++; \
	$display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end

module tio_port_block_tb;
	logic clk_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic [7:0] addr_i = 8'h00;
	logic [31:0] wdata_i = 32'h0;
	logic we_i = 1'b0;
	logic re_i = 1'b0;
	logic link_en_i = 1'b0;
	logic [31:0] rdata_o, pin_i, pin_o, pin_oe_o, pin_pd_o;
	logic strobe_in_ready_i, strobe_out_valid_o, irq_o;
	logic [4:0] events_o;
	logic [31:0] ext_oe = 32'h0;
	logic [31:0] ext_val = 32'h0;
	logic rdy = 1'b0;
	logic re_d = 1'b0;
	logic [31:0] last, cap, d, d1, d2, eq, mq;
	logic [31:0] exp_q[$], msk_q[$];
	int errors = 0;
	int n_compared = 0;
	int stb_n = 0;
	int ev_n[5] = '{default: 0};
	logic [15:0] lfsr_ff = 16'hd0d7; // seed 53463
	tio_pkg::tio_ctrl_s ctl;

	always #20 clk_i = ~clk_i;

	tio_port_block #(.PIN_W(32), .LINK_PINS(32'h0000_00f0)) i_dut (
		.clk_i(clk_i), .sys_rst_i(sys_rst_i), .addr_i(addr_i),
		.wdata_i(wdata_i), .we_i(we_i), .re_i(re_i), .rdata_o(rdata_o),
		.pin_i(pin_i), .pin_o(pin_o), .pin_oe_o(pin_oe_o),
		.pin_pd_o(pin_pd_o), .strobe_in_ready_i(strobe_in_ready_i),
		.strobe_out_valid_o(strobe_out_valid_o), .link_en_i(link_en_i),
		.events_o(events_o), .irq_o(irq_o));

	tio_pin_model i_pins (.clk_i(clk_i), .drv_i(pin_o), .oe_i(pin_oe_o),
		.pd_i(pin_pd_o), .ext_oe_i(ext_oe), .ext_val_i(ext_val),
		.rdy_i(rdy), .pin_o(pin_i), .ready_o(strobe_in_ready_i));

	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction

	task automatic rnd(output logic [31:0] v);
		lfsr_ff = lfsr(lfsr_ff);
		v[15:0] = lfsr_ff;
		lfsr_ff = lfsr(lfsr_ff);
		v[31:16] = lfsr_ff;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk_i);
		we_i <= 1'b1;
		addr_i <= a;
		wdata_i <= v;
		@(posedge clk_i);
		we_i <= 1'b0;
	endtask

	// a zero mask only captures the word, for relative checks
	task automatic rd(input logic [7:0] a, input logic [31:0] e,
		input logic [31:0] m);
		@(posedge clk_i);
		re_i <= 1'b1;
		addr_i <= a;
		exp_q.push_back(e & m);
		msk_q.push_back(m);
		@(posedge clk_i);
		re_i <= 1'b0;
	endtask

	task automatic rd_cap(input logic [7:0] a);
		rd(a, 32'h0, 32'h0);
		@(posedge clk_i);
		#1 cap = last;
	endtask

	always @(posedge clk_i) begin
		if (re_d) begin
			last = rdata_o;
			eq = exp_q.pop_front();
			mq = msk_q.pop_front();
			if (|mq)
				`CHK(rdata_o & mq, eq)
		end
		re_d <= re_i;
		if (strobe_out_valid_o === 1'b1)
			stb_n++;
		for (int p = 0; p < 5; p++)
			if (events_o[p] === 1'b1)
				ev_n[p]++;
	end

	task automatic stop_test();
		$display("compared %0d errors %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	initial begin
		#(40 * 4000);
		errors++;
		stop_test();
	end

	initial begin
		repeat (4) @(posedge clk_i);
		`CHK(pin_pd_o, {32{1'b1}})
		`CHK(pin_oe_o, 32'h0)
		sys_rst_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		`CHK(pin_pd_o, 32'h0)
		for (int p = 0; p < 5; p++)
			rd(8'(p * 8), 32'h0, 32'h380);
		rd(8'h7f, 32'h0, {32{1'b1}});
		wr(8'h81, 32'h1f);
		rnd(d2);
		rnd(d1);
		wr(8'h10, 32'h43);
		wr(8'h11, d2);
		repeat (4) @(posedge clk_i);
		`CHK(pin_o[7:0], d2[7:0])
		`CHK(pin_oe_o, 32'h0000_00ff)
		wr(8'h08, 32'h47);
		wr(8'h09, d1);
		repeat (4) @(posedge clk_i);
		`CHK(pin_oe_o[3:0], ~d1[3:0])
		`CHK(pin_o[3:0], 4'h0)
		`CHK(pin_oe_o[7:4], 4'hf)
		`CHK(pin_o[7:4], d2[7:4])
		`CHK(stb_n, 2)
		`CHK(ev_n[2], 1)
		`CHK(ev_n[1], 1)
		link_en_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		`CHK(pin_oe_o[7:0], {4'h0, ~d1[3:0]})
		link_en_i <= 1'b0;
		`CHK(irq_o, 1'b1)
		rd(8'h80, 32'h6, {32{1'b1}});
		wr(8'h81, 32'h0);
		repeat (2) @(posedge clk_i);
		`CHK(irq_o, 1'b0)
		wr(8'h81, 32'h4);
		repeat (2) @(posedge clk_i);
		`CHK(irq_o, 1'b1)
		wr(8'h80, 32'h4);
		repeat (2) @(posedge clk_i);
		`CHK(irq_o, 1'b0)
		rd(8'h80, 32'h2, {32{1'b1}});
		// timestamp lands four edges after the count sample
		rd_cap(8'h14);
		wr(8'h11, d1);
		rd(8'h15, cap + 32'h4, 32'h0000_ffff);
		rd_cap(8'h14);
		d = cap;
		rd_cap(8'h14);
		`CHK((cap - d) & 32'h0000_ffff, 32'h3)
		`CHK(ev_n[2], 2)
		wr(8'h10, 32'h0);
		wr(8'h08, 32'h0);
		wr(8'h03, 32'h1);
		ext_oe <= 32'h1;
		rdy <= 1'b1;
		ctl = '0;
		ctl.en = 1'b1;
		ctl.cond = tio_pkg::TIO_COND_EQ;
		ctl.strobe_en = 1'b1;
		wr(8'h00, {22'h0, ctl});
		repeat (10) @(posedge clk_i);
		`CHK(ev_n[0], 0)
		rdy <= 1'b0;
		ext_val <= 32'h1;
		repeat (10) @(posedge clk_i);
		`CHK(ev_n[0], 0)
		rdy <= 1'b1;
		repeat (10) @(posedge clk_i);
		`CHK(ev_n[0], 1)
		rd(8'h01, 32'h1, {32{1'b1}});
		repeat (10) @(posedge clk_i);
		`CHK(ev_n[0], 2)
		// timed output: the word waits for the programmed count
		wr(8'h00, 32'h0);
		rd_cap(8'h14);
		d = (cap + 32'h40) & 32'h0000_ffff;
		wr(8'h12, d);
		wr(8'h10, 32'h23);
		wr(8'h11, d1);
		repeat (20) @(posedge clk_i);
		`CHK(ev_n[2], 2)
		repeat (60) @(posedge clk_i);
		`CHK(ev_n[2], 3)
		rd(8'h15, d, 32'h0000_ffff);
		wr(8'h10, 32'h0);
		// port 3 paced by block 1 from pin 0, one tick per two rising edges
		rd(8'h88, 32'h0, {32{1'b1}});
		wr(8'h89, 32'h101);
		rd(8'h89, 32'h101, {32{1'b1}});
		wr(8'h18, 32'h81);
		rd_cap(8'h1c);
		d = cap;
		repeat (8) begin
			ext_val <= 32'h0;
			repeat (3) @(posedge clk_i);
			ext_val <= 32'h1;
			repeat (3) @(posedge clk_i);
		end
		rd_cap(8'h1c);
		`CHK((cap - d) & 32'h0000_ffff, 32'h4)
		`CHK(ev_n[3], 1)
		stop_test();
	end
endmodule // tio_port_block_tb
